// file: i2cmsc_top.v
`timescale 1ns/1ps
`include "i2cmsc_consts.vh"
// Behaviour
// [RULE_01] ack enable starts ack sequence
// [RULE_02] send ack data, clear when done
// [RULE_03] ack data 1 NACK, 0 ACK
// [RULE_04] enable bits read 0 when idle
// [RULE_05] bit 3 enables master receive
// [RULE_06] bit 2 generates STOP
// [RULE_07] stop enable self-clears after STOP
// [RULE_08] sets ignored while busy, never queued
// [RULE_09] buffer writes blocked while busy
// [RULE_10] software waits for idle first
// [RULE_11] receive enable clears after byte
module i2cmsc_top #(
	parameter DIV_W = 16
) (
	input wire i_sys_clk, // 125 MHz core clock
	input wire i_nrst, // sync reset, active low
	input wire i_psel, // apb select
	input wire i_penable, // apb enable
	input wire i_pwrite, // apb direction
	input wire [11:0] i_paddr, // apb byte address
	input wire [31:0] i_pwdata, // apb write data
	output wire o_pready, // apb ready
	output reg [31:0] o_prdata, // apb read data
	output wire o_pslverr, // apb error
	input wire i_scl_in, // clock line level
	input wire i_sda_in, // data line level
	output wire o_scl_out, // clock drive value
	output wire o_scl_oe_n, // clock drive enable, low drives
	output wire o_sda_out, // data drive value
	output wire o_sda_oe_n, // data drive enable, low drives
	output wire o_idle // port idle indication
);
	reg ack_sequence_enable_reg;
	reg ack_data_level_reg;
	reg receive_enable_ctl_reg;
	reg stop_generate_enable_reg;
	reg master_mode_reg;
	reg [7:0] serial_port_buffer_reg;
	reg rx_full_reg;
	reg [DIV_W-1:0] div_reg;
	reg [1:0] sda_sync_reg;
	reg [1:0] scl_sync_reg;
	reg start_reg;
	reg [1:0] cmd_reg;
	wire eng_done;
	wire [7:0] eng_rx;
	wire busy = ack_sequence_enable_reg | receive_enable_ctl_reg |
		stop_generate_enable_reg;
	wire wr = i_psel & i_penable & i_pwrite;
	wire known = (i_paddr == `I2CMSC_ADDR_CTRL) || (i_paddr == `I2CMSC_ADDR_BUF) ||
		(i_paddr == `I2CMSC_ADDR_STAT) || (i_paddr == `I2CMSC_ADDR_DIV);
	wire ctrl_wr = wr && (i_paddr == `I2CMSC_ADDR_CTRL);
	wire rd_buf = i_psel & i_penable & ~i_pwrite & (i_paddr == `I2CMSC_ADDR_BUF);
	// [RULE_08] requests only taken when idle
	// master bit comes from the same write, so one write can select master mode and launch
	wire ok = ctrl_wr & ~busy & i_pwdata[`I2CMSC_BIT_MASTER];
	wire set_ack = ok & i_pwdata[`I2CMSC_BIT_ACKSEQ];
	wire set_rcv = ok & ~set_ack & i_pwdata[`I2CMSC_BIT_RCV];
	wire set_stop = ok & ~set_ack & ~set_rcv & i_pwdata[`I2CMSC_BIT_STOP];
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~known;
	assign o_scl_out = 1'b0;
	assign o_sda_out = 1'b0;
	assign o_idle = ~busy;
	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			sda_sync_reg <= 2'h3;
			scl_sync_reg <= 2'h3;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], i_sda_in};
			scl_sync_reg <= {scl_sync_reg[0], i_scl_in};
		end
	end
	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			ack_sequence_enable_reg <= 1'b0;
			ack_data_level_reg <= 1'b0;
			receive_enable_ctl_reg <= 1'b0;
			stop_generate_enable_reg <= 1'b0;
			master_mode_reg <= 1'b0;
			serial_port_buffer_reg <= 8'h00;
			rx_full_reg <= 1'b0;
			div_reg <= `I2CMSC_DIV_RESET;
			start_reg <= 1'b0;
			cmd_reg <= 2'h0;
		end else begin
			start_reg <= set_ack | set_rcv | set_stop;
			if (ctrl_wr) begin
				ack_data_level_reg <= i_pwdata[`I2CMSC_BIT_ACKDATA];
				if (!busy)
					master_mode_reg <= i_pwdata[`I2CMSC_BIT_MASTER];
			end
			if (wr && i_paddr == `I2CMSC_ADDR_DIV && !busy)
				div_reg <= i_pwdata[DIV_W-1:0];
			// [RULE_01] launch ack sequence
			if (set_ack) begin
				ack_sequence_enable_reg <= 1'b1;
				cmd_reg <= 2'h1;
			end
			// [RULE_05] enter receive mode
			if (set_rcv) begin
				receive_enable_ctl_reg <= 1'b1;
				cmd_reg <= 2'h2;
			end
			// [RULE_06] request stop condition
			if (set_stop) begin
				stop_generate_enable_reg <= 1'b1;
				cmd_reg <= 2'h3;
			end
			// [RULE_09] buffer write only when idle
			if (wr && i_paddr == `I2CMSC_ADDR_BUF && !busy)
				serial_port_buffer_reg <= i_pwdata[7:0];
			if (rd_buf)
				rx_full_reg <= 1'b0;
			if (eng_done) begin
				// [RULE_02] ack enable self-clears
				ack_sequence_enable_reg <= 1'b0;
				// [RULE_07] stop enable self-clears
				stop_generate_enable_reg <= 1'b0;
				// [RULE_11] byte stored, receive ends
				if (receive_enable_ctl_reg) begin
					receive_enable_ctl_reg <= 1'b0;
					serial_port_buffer_reg <= eng_rx;
					rx_full_reg <= 1'b1;
				end
			end
		end
	end
	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_prdata <= 32'h00000000;
		end else begin
			o_prdata <= 32'h00000000;
			if (i_psel && !i_penable && !i_pwrite) begin
				if (i_paddr == `I2CMSC_ADDR_CTRL) begin
					// [RULE_04] enable bits read live state
					o_prdata[`I2CMSC_BIT_STOP] <= stop_generate_enable_reg;
					o_prdata[`I2CMSC_BIT_RCV] <= receive_enable_ctl_reg;
					o_prdata[`I2CMSC_BIT_ACKSEQ] <= ack_sequence_enable_reg;
					o_prdata[`I2CMSC_BIT_ACKDATA] <= ack_data_level_reg;
					o_prdata[`I2CMSC_BIT_MASTER] <= master_mode_reg;
				end else if (i_paddr == `I2CMSC_ADDR_BUF) begin
					o_prdata[7:0] <= serial_port_buffer_reg;
				end else if (i_paddr == `I2CMSC_ADDR_STAT) begin
					o_prdata[`I2CMSC_BIT_IDLE] <= ~busy;
					o_prdata[`I2CMSC_BIT_BUSY] <= busy;
					o_prdata[`I2CMSC_BIT_RXFULL] <= rx_full_reg;
					o_prdata[`I2CMSC_BIT_SCL] <= scl_sync_reg[1];
					o_prdata[`I2CMSC_BIT_SDA] <= sda_sync_reg[1];
				end else if (i_paddr == `I2CMSC_ADDR_DIV) begin
					o_prdata[DIV_W-1:0] <= div_reg;
				end
			end
		end
	end
	i2cmsc_seq_engine #(.DIV_W(DIV_W)) u_engine (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_div(div_reg),
		.i_cmd(cmd_reg),
		.i_start(start_reg),
		.i_ack_level(ack_data_level_reg),
		.i_sda_in(sda_sync_reg[1]),
		.o_done(eng_done),
		.o_rx_byte(eng_rx),
		.o_scl_oe_n(o_scl_oe_n),
		.o_sda_oe_n(o_sda_oe_n)
	);
endmodule

// file: i2cmsc_consts.vh
`ifndef I2CMSC_CONSTS_VH
`define I2CMSC_CONSTS_VH
// register byte addresses
`define I2CMSC_ADDR_CTRL 12'h000
`define I2CMSC_ADDR_BUF 12'h004
`define I2CMSC_ADDR_STAT 12'h008
`define I2CMSC_ADDR_DIV 12'h00c
// control register fields
`define I2CMSC_BIT_STOP 2
`define I2CMSC_BIT_RCV 3
`define I2CMSC_BIT_ACKSEQ 4
`define I2CMSC_BIT_ACKDATA 5
`define I2CMSC_BIT_MASTER 7
// status register fields
`define I2CMSC_BIT_IDLE 0
`define I2CMSC_BIT_BUSY 1
`define I2CMSC_BIT_RXFULL 2
`define I2CMSC_BIT_SCL 4
`define I2CMSC_BIT_SDA 5
// divider reset value and bits per byte
`define I2CMSC_DIV_RESET 16'h0004
`define I2CMSC_BYTE_BITS 4'h8
`endif

// file: i2cmsc_seq_engine.v
`timescale 1ns/1ps
`include "i2cmsc_consts.vh"
// bit-level engine: one quarter-phase per divider wrap, four quarters per bit
module i2cmsc_seq_engine #(
	parameter DIV_W = 16
) (
	input wire i_sys_clk, // core clock
	input wire i_nrst, // sync reset, active low
	input wire [DIV_W-1:0] i_div, // quarter-bit period in clocks, minus one
	input wire [1:0] i_cmd, // 1 ack, 2 receive, 3 stop
	input wire i_start, // one-cycle launch
	input wire i_ack_level, // level sent in ack slot
	input wire i_sda_in, // synchronised data line
	output reg o_done, // one-cycle completion pulse
	output reg [7:0] o_rx_byte, // received byte
	output reg o_scl_oe_n, // low pulls clock low
	output reg o_sda_oe_n // low pulls data low
);
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	reg [1:0] state_reg;
	reg [1:0] cmd_reg;
	reg [DIV_W-1:0] cnt_reg;
	reg [1:0] quarter_reg;
	reg [3:0] bits_reg;
	wire tick = (cnt_reg == {DIV_W{1'b0}});
	wire last_q = (quarter_reg == 2'h3);
	wire [3:0] nbits = (cmd_reg == 2'h2) ? `I2CMSC_BYTE_BITS : 4'h1;
	always @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		if (!i_nrst) begin
			state_reg <= ST_IDLE;
			cmd_reg <= 2'h0;
			cnt_reg <= {DIV_W{1'b0}};
			quarter_reg <= 2'h0;
			bits_reg <= 4'h0;
			o_rx_byte <= 8'h00;
			o_scl_oe_n <= 1'b1;
			o_sda_oe_n <= 1'b1;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (i_start) begin
					state_reg <= ST_RUN;
					cmd_reg <= i_cmd;
					cnt_reg <= i_div;
					quarter_reg <= 2'h0;
					bits_reg <= 4'h0;
					// clock held low while data is set up
					o_scl_oe_n <= 1'b0;
					// stop begins with data low
					o_sda_oe_n <= (i_cmd == 2'h3) ? 1'b0 : 1'b1;
				end
			end
			default: begin
				cnt_reg <= tick ? i_div : cnt_reg - 1'b1;
				if (tick) begin
					quarter_reg <= quarter_reg + 2'h1;
					case (quarter_reg)
					2'h0: begin
						// [RULE_03] ack slot level
						if (cmd_reg == 2'h1)
							o_sda_oe_n <= i_ack_level;
						else if (cmd_reg == 2'h2)
							o_sda_oe_n <= 1'b1;
					end
					2'h1: o_scl_oe_n <= 1'b1;
					2'h2: begin
						if (cmd_reg == 2'h2)
							o_rx_byte <= {o_rx_byte[6:0], i_sda_in};
						// [RULE_06] data rises while clock high
						if (cmd_reg == 2'h3)
							o_sda_oe_n <= 1'b1;
					end
					default: begin
						if (cmd_reg != 2'h3)
							o_scl_oe_n <= 1'b0;
						bits_reg <= bits_reg + 4'h1;
						if (bits_reg + 4'h1 == nbits) begin
							state_reg <= ST_IDLE;
							o_done <= 1'b1;
							if (cmd_reg == 2'h1)
								o_sda_oe_n <= 1'b1;
						end
					end
					endcase
				end
				if (tick && last_q && cmd_reg == 2'h3)
					o_scl_oe_n <= 1'b1;
			end
			endcase
		end
	end
endmodule

// file: i2cmsc_chk.sv
`timescale 1ns/1ps
module i2cmsc_chk (
	input wire i_sys_clk,
	input wire i_nrst,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire o_scl_out,
	input wire o_sda_out,
	input wire o_idle
);
	wire ctl_wr = i_psel && i_penable && i_pwrite && i_paddr == 12'h000;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	a_ack_start: assert property (
		o_idle && ctl_wr && i_pwdata[7] && i_pwdata[4] |=> !o_idle) else $error("ack not started");
	a_rcv_start: assert property (
		o_idle && ctl_wr && i_pwdata[7] && i_pwdata[3] |=> !o_idle) else $error("receive not started");
	a_stop_start: assert property (
		o_idle && ctl_wr && i_pwdata[7] && i_pwdata[2] |=> !o_idle) else $error("stop not started");
	a_master_only: assert property (
		o_idle && ctl_wr && !i_pwdata[7] |=> o_idle) else $error("started outside master mode");
	a_idle_keep: assert property (
		o_idle && !ctl_wr |=> o_idle) else $error("sequence began without a request");
	a_busy_hold: assert property (
		$fell(o_idle) |-> !o_idle [*8]) else $error("sequence ended too soon");
	a_seq_ends: assert property (
		$fell(o_idle) |-> ##[4:400] o_idle) else $error("sequence never finished");
	a_open_drain: assert property (
		!o_scl_out && !o_sda_out) else $error("line driven high");
endmodule
bind i2cmsc_top i2cmsc_chk u_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_scl_out(o_scl_out), .o_sda_out(o_sda_out), .o_idle(o_idle));

// file: i2cmsc_slave_model.sv
`timescale 1ns/1ps
module i2cmsc_slave_model (
	input wire i_scl, // clock line level
	input wire i_en, // rising edge restarts the byte
	input wire [7:0] i_byte, // byte to send, msb first
	output wire o_sda // low pulls data low
);
	int idx;
	bit seen;
	always @(posedge i_en) begin
		idx = 0;
		seen = 0;
	end
	always @(posedge i_scl) seen = 1;
	// a fall before the first rise must not skip bit 7
	always @(negedge i_scl) if (seen) idx++;
	assign o_sda = (i_en && idx < 8) ? i_byte[7 - idx] : 1'b1;
endmodule

// file: i2c_master_sequence_control_tb.sv
`timescale 1ns/1ps
module i2c_master_sequence_control_tb;
	logic i_sys_clk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, er, lo, s_en = 0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0, rd;
	logic [7:0] s_byte = 8'h00;
	wire o_pready, o_pslverr, o_scl_out, o_scl_oe_n, o_sda_out, o_sda_oe_n, o_idle, s_sda;
	wire [31:0] o_prdata;
	// pull-ups on both lines
	wire scl = o_scl_oe_n ? 1'b1 : o_scl_out;
	wire sda = (o_sda_oe_n ? 1'b1 : o_sda_out) & s_sda;
	int failures = 0, checked = 0;
	i2cmsc_top DUT (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
		.o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_scl_in(scl), .i_sda_in(sda),
		.o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n), .o_sda_out(o_sda_out),
		.o_sda_oe_n(o_sda_oe_n), .o_idle(o_idle));
	i2cmsc_slave_model SLV (.i_scl(scl), .i_en(s_en), .i_byte(s_byte), .o_sda(s_sda));
	initial forever #4 i_sys_clk = ~i_sys_clk;
	always @(negedge i_sys_clk) if (o_sda_oe_n === 1'b0) lo = 1;
	task wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input bit w, input [11:0] a, input [31:0] d);
		logic r;
		int n;
		@(posedge i_sys_clk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_sys_clk);
		i_penable <= 1;
		n = 0;
		// answer taken at the very edge that samples pready high
		do begin
			@(posedge i_sys_clk);
			r = o_pready;
			rd = o_prdata;
			er = o_pslverr;
			n++;
		end while (r !== 1'b1 && n < 50);
		if (r !== 1'b1) begin
			failures++;
			wrap_up;
		end
		i_psel <= 0;
		i_penable <= 0;
	endtask
	task wait_clr(input [31:0] m);
		for (int n = 0; n < 300; n++) begin
			apb(0, 12'h000, 32'h0);
			if ((rd & m) === 32'h0) return;
		end
		failures++;
		wrap_up;
	endtask
	task run(input [31:0] c, input [31:0] m, input [31:0] el);
		lo = 0;
		apb(1, 12'h000, c);
		wait_clr(m);
		chk("sda pulled", {31'h0, lo}, el);
	endtask
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_nrst <= 1;
		apb(0, 12'h000, 32'h0);
		chk("ctrl", rd, 32'h0);
		apb(0, 12'h00c, 32'h0);
		chk("div", rd, 32'h4);
		apb(0, 12'h008, 32'h0);
		chk("stat", rd, 32'h31);
		apb(1, 12'h004, 32'h5a);
		apb(0, 12'h004, 32'h0);
		chk("buf", rd, 32'h5a);
		run(32'hb0, 32'h10, 32'h0);
		run(32'h90, 32'h10, 32'h1);
		s_byte <= 8'ha5;
		s_en <= 1;
		run(32'h88, 32'h08, 32'h0);
		apb(0, 12'h004, 32'h0);
		chk("buf", rd, 32'ha5);
		s_en <= 0;
		s_byte <= 8'h3c;
		@(posedge i_sys_clk);
		s_en <= 1;
		apb(1, 12'h000, 32'h88);
		apb(1, 12'h000, 32'h84);
		wait_clr(32'h08);
		chk("ctrl", rd, 32'h80);
		apb(0, 12'h004, 32'h0);
		chk("buf", rd, 32'h3c);
		// buffer write issued during an ack sequence is blocked while busy, so the buffer keeps 3c
		apb(1, 12'h000, 32'h90);
		apb(1, 12'h004, 32'hff);
		wait_clr(32'h10);
		apb(0, 12'h004, 32'h0);
		chk("buf", rd, 32'h3c);
		run(32'h84, 32'h04, 32'h1);
		chk("lines", {30'h0, o_scl_oe_n, o_sda_oe_n}, 32'h3);
		apb(1, 12'h000, 32'h10);
		apb(0, 12'h000, 32'h0);
		chk("ctrl", rd, 32'h0);
		apb(0, 12'h010, 32'h0);
		chk("slverr", {31'h0, er}, 32'h1);
		wrap_up;
	end
endmodule
